// ### rtl/boot_loader_map.svh
/*
  Named offsets, fields, codes and timing for the self boot loader.
  Assumes inclusion by bare name from the loader module and the bench.
*/
`ifndef BOOT_LOADER_MAP_SVH
`define BOOT_LOADER_MAP_SVH
// register indices; byte address is four times the index
`define BL_IDX_FLAG   16'hf427
`define BL_IDX_CAUSE  16'hf428
`define BL_IDX_CTRL   16'hf429
// image format
`define BL_SENTINEL   8'haa
`define BL_HDR_END    4'hf
`define BL_BHDR_END   4'h7
`define BL_FOOT_END   4'h7
`define BL_WORD_END   2'h3
`define BL_F_FIRST    119:96
`define BL_F_DIV      87:80
`define BL_F_FB       71:64
`define BL_F_CHK      55:48
`define BL_F_MCLK     39:32
`define BL_F_SPEED    31:0
`define BL_F_LAST     63
`define BL_F_BANK     49:48
`define BL_F_BASE     47:32
`define BL_F_LEN      31:16
`define BL_F_JUMP     15:0
`define BL_BANK_BAD   2'h3
`define BL_TRIES      2'h3
// link framing
`define BL_SPI_READ   8'h03
`define BL_I2C_WR     8'ha0
`define BL_I2C_RD     8'ha1
`define BL_SPI_BITS   6'd39
`define BL_I2C_ACK    4'h8
`define BL_I2C_RSTART 3'h2
`define BL_I2C_RDBYTE 3'h4
// panic causes
`define BL_C_NONE     4'h0
`define BL_C_SENT     4'h1
`define BL_C_PLL      4'h2
`define BL_C_BANK     4'h3
`define BL_C_NACK     4'h4
`define BL_C_SUM      4'h5
// timing: quarter bit periods, rounded up
`define BL_CLK_NS     20
`define BL_SPI_NS     1000
`define BL_I2C_NS     10000
`define BL_SPI_QTR    ((`BL_SPI_NS / 4 + `BL_CLK_NS - 1) / `BL_CLK_NS)
`define BL_I2C_QTR    ((`BL_I2C_NS / 4 + `BL_CLK_NS - 1) / `BL_CLK_NS)
`endif

// ### rtl/bl_pkg.sv
/*
  Types of the self boot loader: loader and link state enumerations.
  Assumes nothing of its surroundings.
*/
package bl_pkg;
  typedef enum logic [2:0] {IDLE, HDR, BHDR, DATA, FOOT, DONE, PANIC} boot_state_t;
  typedef enum logic [1:0] {L_IDLE, L_START, L_BITS, L_STOP} link_state_t;
endpackage

// ### rtl/eeprom_self_boot_loader.sv
/*
  Self boot loader: fetches a boot image byte by byte from a serial EEPROM over
  SPI or I2C, loads blocks into memory, checks the footer sum and starts the core.
  Assumes synchronous pin inputs, external pull-ups on the I2C lines and an APB master.
*/
// Functional notes
// R1: three attempts, then panic and sleep
// R2: panic only visible in flag and cause registers
// R3: header, blocks, footer parsed in order
// R4: header is 16 bytes from address 0
// R5: first byte must be sentinel 0xaa
// R6: 24-bit pointer gives first block address
// R7: apply pll settings, check byte is their sum
// R8: eight-byte block header then four-byte packets
// R9: last flag set means footer follows
// R10: producer writes reserved bits as zero
// R11: bank select 0,1 data, 2 program
// R12: words stored from base address upward
// R13: length counts 32-bit words in block
// R14: jump address taken from last block only
// R15: footer is 64-bit sum of 32-bit words
// R16: sum mismatch raises a panic
// R17: zero footer skips the sum check
// R18: split i2c memory treated as separate part
// R19: block header byte order, msb first
// R20: pll values in odd header bytes, speed last
// R21: boot on reset release while enable high
// R22: select pin low at start picks i2c
// R23: spi read command 0x03, mode 3, msb first
// R24: i2c device 0x50 with 16-bit address
`timescale 1ns/1ps
`include "boot_loader_map.svh"
module eeprom_self_boot_loader #(
  parameter int SPI_QTR = `BL_SPI_QTR,
  parameter int I2C_QTR = `BL_I2C_QTR
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        boot_enable_pin,
  input  wire logic        select_pin_i,
  output logic             select_pin_o,
  output logic             select_pin_oe,
  output logic             mosi_o,
  output logic             mosi_oe,
  output logic             clk_pin_o,
  output logic             clk_pin_oe,
  input  wire logic        data_pin_i,
  output logic             data_pin_o,
  output logic             data_pin_oe,
  output logic      [7:0]  pll_input_divider,
  output logic      [7:0]  pll_feedback_divider,
  output logic      [7:0]  pll_clock_out,
  output logic             pll_load,
  output logic      [31:0] mem_speed,
  output logic             mem_wr_en,
  output logic      [1:0]  mem_bank,
  output logic      [15:0] mem_addr,
  output logic      [31:0] mem_wdata,
  output logic             core_run,
  output logic      [15:0] core_jump_addr,
  output logic             core_sleep
);
  bl_pkg::boot_state_t st;
  bl_pkg::link_state_t lk;
  logic [7:0]   div;
  logic         tick;
  logic [1:0]   q;
  logic [5:0]   bitn;
  logic [3:0]   ibit;
  logic [2:0]   byten;
  logic [39:0]  tx;
  logic [7:0]   rx;
  logic         clk_lvl;
  logic         sda_lvl;
  logic         cs_lvl;
  logic         mosi_lvl;
  logic         lk_req;
  logic         lk_done;
  logic         lk_nack;
  logic         spi_mode;
  logic         pending_boot;
  logic         sw_go;
  logic         pend;
  logic [23:0]  ptr;
  logic [3:0]   cnt;
  logic [119:0] img;
  logic [63:0]  sum;
  logic [1:0]   attempt;
  logic         last;
  logic [15:0]  base;
  logic [15:0]  left;
  logic [15:0]  jump;
  logic [3:0]   cause;
  logic         panic;
  logic         fault;
  logic [3:0]   fault_code;
  logic [31:0]  rd;
  wire  [127:0] nb      = {img, rx};
  wire          got     = pend & lk_done;
  wire          active  = (st != bl_pkg::IDLE) && (st != bl_pkg::DONE) && (st != bl_pkg::PANIC);
  wire          setup   = psel & ~penable;
  wire  [15:0]  idx     = paddr[17:2];
  wire          hit     = (idx == `BL_IDX_FLAG) || (idx == `BL_IDX_CAUSE) || (idx == `BL_IDX_CTRL);
  wire          ctrl_wr = psel & penable & pready & pwrite & (idx == `BL_IDX_CTRL) & pwdata[0];
  wire  [7:0]   pll_sum = 8'(nb[`BL_F_DIV] + nb[`BL_F_FB] + nb[`BL_F_MCLK]);

  // quarter-bit enable; the rate follows the link chosen at boot start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div  <= 8'h00;
      tick <= 1'b0;
    end else begin
      tick <= (div == 8'h00);
      if (div == 8'h00) begin
        div <= spi_mode ? 8'(SPI_QTR - 1) : 8'(I2C_QTR - 1);
      end else begin
        div <= div - 8'h01;
      end
    end
  end

  // byte link: one whole addressed read per byte, slow but identical for both buses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lk       <= bl_pkg::L_IDLE;
      q        <= 2'h0;
      bitn     <= 6'h00;
      ibit     <= 4'h0;
      byten    <= 3'h0;
      tx       <= 40'h00_0000_0000;
      rx       <= 8'h00;
      clk_lvl  <= 1'b1;
      sda_lvl  <= 1'b1;
      cs_lvl   <= 1'b1;
      mosi_lvl <= 1'b1;
      lk_done  <= 1'b0;
      lk_nack  <= 1'b0;
    end else begin
      lk_done <= 1'b0;
      case (lk)
        bl_pkg::L_IDLE: if (lk_req) begin
          lk      <= spi_mode ? bl_pkg::L_BITS : bl_pkg::L_START;
          q       <= 2'h0;
          bitn    <= 6'h00;
          ibit    <= 4'h0;
          byten   <= 3'h0;
          lk_nack <= 1'b0;
          cs_lvl  <= ~spi_mode;
          if (spi_mode) begin
            tx <= {`BL_SPI_READ, ptr, 8'hff}; // R23
          end else begin
            tx <= {`BL_I2C_WR, ptr[15:0], `BL_I2C_RD, 8'hff}; // R24
          end
        end
        bl_pkg::L_START: if (tick) begin
          // sda falls while scl is high; also serves as repeated start
          q <= q + 2'h1;
          case (q)
            2'h0: sda_lvl <= 1'b1;
            2'h1: clk_lvl <= 1'b1;
            2'h2: sda_lvl <= 1'b0;
            default: begin
              clk_lvl <= 1'b0;
              lk      <= bl_pkg::L_BITS;
            end
          endcase
        end
        bl_pkg::L_BITS: if (tick) begin
          q <= q + 2'h1;
          if (spi_mode) begin
            // mode 3: shift out on falling edge, sample after rising
            case (q)
              2'h0: begin
                clk_lvl  <= 1'b0;
                mosi_lvl <= tx[39]; // R23
              end
              2'h2: clk_lvl <= 1'b1;
              2'h3: begin
                rx   <= {rx[6:0], data_pin_i};
                tx   <= {tx[38:0], 1'b1};
                bitn <= bitn + 6'h01;
                if (bitn == `BL_SPI_BITS) begin
                  lk <= bl_pkg::L_STOP;
                end
              end
              default: ;
            endcase
          end else begin
            case (q)
              2'h0: begin
                clk_lvl <= 1'b0;
                // released on ack slots and throughout the read byte, which ends in a nack
                sda_lvl <= (ibit == `BL_I2C_ACK) || (byten == `BL_I2C_RDBYTE) || tx[39];
              end
              2'h1: clk_lvl <= 1'b1;
              2'h2: begin
                if (ibit != `BL_I2C_ACK) begin
                  rx <= {rx[6:0], data_pin_i};
                end else if (byten != `BL_I2C_RDBYTE && data_pin_i) begin
                  lk_nack <= 1'b1;
                end
              end
              default: begin
                clk_lvl <= 1'b0;
                ibit    <= ibit + 4'h1;
                if (ibit != `BL_I2C_ACK) begin
                  tx <= {tx[38:0], 1'b1};
                end else begin
                  ibit  <= 4'h0;
                  byten <= byten + 3'h1;
                  if (byten == `BL_I2C_RSTART) begin
                    lk <= bl_pkg::L_START;
                  end else if (byten == `BL_I2C_RDBYTE) begin
                    lk <= bl_pkg::L_STOP;
                  end
                end
              end
            endcase
          end
        end
        bl_pkg::L_STOP: if (tick) begin
          // spi deselects; i2c raises sda while scl is high
          q <= q + 2'h1;
          case (q)
            2'h0: begin
              cs_lvl  <= 1'b1;
              clk_lvl <= spi_mode;
              sda_lvl <= 1'b0;
            end
            2'h1: clk_lvl <= 1'b1;
            2'h2: sda_lvl <= 1'b1;
            default: begin
              lk_done <= 1'b1;
              lk      <= bl_pkg::L_IDLE;
            end
          endcase
        end
        default: lk <= bl_pkg::L_IDLE;
      endcase
    end
  end

  // pin drivers; pins stay released outside a load, so no panic level reaches them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      select_pin_o  <= 1'b1;
      select_pin_oe <= 1'b0;
      mosi_o        <= 1'b1;
      mosi_oe       <= 1'b0;
      clk_pin_o     <= 1'b1;
      clk_pin_oe    <= 1'b0;
      data_pin_o    <= 1'b0;
      data_pin_oe   <= 1'b0;
    end else begin
      select_pin_o  <= cs_lvl;
      select_pin_oe <= active & spi_mode;
      mosi_o        <= mosi_lvl;
      mosi_oe       <= active & spi_mode;
      clk_pin_o     <= ~spi_mode | clk_lvl;
      clk_pin_oe    <= active & (spi_mode | ~clk_lvl);
      data_pin_o    <= 1'b0;
      data_pin_oe   <= active & ~spi_mode & ~sda_lvl;
    end
  end

  // fault detection on each arriving byte, first cause wins
  always_comb begin
    fault      = 1'b0;
    fault_code = `BL_C_NONE;
    if (got) begin
      if (lk_nack) begin
        fault      = 1'b1;
        fault_code = `BL_C_NACK;
      end else if (st == bl_pkg::HDR && cnt == 4'h0 && rx != `BL_SENTINEL) begin
        fault      = 1'b1; // R5
        fault_code = `BL_C_SENT;
      end else if (st == bl_pkg::HDR && cnt == `BL_HDR_END && nb[`BL_F_CHK] != pll_sum) begin
        fault      = 1'b1; // R7
        fault_code = `BL_C_PLL;
      end else if (st == bl_pkg::BHDR && cnt == `BL_BHDR_END &&
                   nb[`BL_F_BANK] == `BL_BANK_BAD) begin
        fault      = 1'b1; // R11
        fault_code = `BL_C_BANK;
      end else if (st == bl_pkg::FOOT && cnt == `BL_FOOT_END && nb[63:0] != 64'h0 &&
                   nb[63:0] != sum) begin
        fault      = 1'b1; // R16 R17
        fault_code = `BL_C_SUM;
      end
    end
  end

  // loader sequence: header, blocks, footer, with retry on any fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st                   <= bl_pkg::IDLE;
      pending_boot         <= 1'b1;
      sw_go                <= 1'b0;
      spi_mode             <= 1'b0;
      pend                 <= 1'b0;
      lk_req               <= 1'b0;
      ptr                  <= 24'h00_0000;
      cnt                  <= 4'h0;
      img                  <= '0;
      sum                  <= 64'h0;
      attempt              <= 2'h0;
      last                 <= 1'b0;
      base                 <= 16'h0000;
      left                 <= 16'h0000;
      jump                 <= 16'h0000;
      cause                <= `BL_C_NONE;
      panic                <= 1'b0;
      pll_input_divider    <= 8'h00;
      pll_feedback_divider <= 8'h00;
      pll_clock_out        <= 8'h00;
      pll_load             <= 1'b0;
      mem_speed            <= 32'h0000_0000;
      mem_wr_en            <= 1'b0;
      mem_bank             <= 2'h0;
      mem_addr             <= 16'h0000;
      mem_wdata            <= 32'h0000_0000;
      core_run             <= 1'b0;
      core_jump_addr       <= 16'h0000;
      core_sleep           <= 1'b0;
    end else begin
      lk_req    <= 1'b0;
      pll_load  <= 1'b0;
      mem_wr_en <= 1'b0;
      // a software start arriving as one is consumed is kept
      sw_go <= ctrl_wr | (sw_go & ~(st == bl_pkg::IDLE));
      case (st)
        bl_pkg::IDLE: begin
          pending_boot <= 1'b0;
          if ((pending_boot & boot_enable_pin) | sw_go) begin // R21
            spi_mode   <= select_pin_i; // R22
            st         <= bl_pkg::HDR;
            ptr        <= 24'h00_0000; // R4
            cnt        <= 4'h0;
            sum        <= 64'h0;
            attempt    <= 2'h0;
            cause      <= `BL_C_NONE;
            panic      <= 1'b0;
            core_run   <= 1'b0;
            core_sleep <= 1'b0;
          end
        end
        bl_pkg::DONE, bl_pkg::PANIC: if (sw_go) begin
          st <= bl_pkg::IDLE;
        end
        default: begin
          if (!pend) begin
            lk_req <= 1'b1;
            pend   <= 1'b1;
          end else if (lk_done) begin
            pend <= 1'b0;
            ptr  <= ptr + 24'h00_0001;
            cnt  <= cnt + 4'h1;
            img  <= nb[119:0];
            if (cnt[1:0] == `BL_WORD_END && st != bl_pkg::FOOT) begin
              sum <= sum + {32'h0000_0000, nb[31:0]}; // R15
            end
            if (fault) begin
              cause <= fault_code; // R2
              if (attempt == `BL_TRIES - 2'h1) begin
                st         <= bl_pkg::PANIC; // R1
                panic      <= 1'b1;
                core_sleep <= 1'b1;
              end else begin
                attempt <= attempt + 2'h1; // R1
                st      <= bl_pkg::HDR;
                ptr     <= 24'h00_0000;
                cnt     <= 4'h0;
                sum     <= 64'h0;
              end
            end else begin
              case (st)
                bl_pkg::HDR: if (cnt == `BL_HDR_END) begin // R3 R20
                  pll_input_divider    <= nb[`BL_F_DIV]; // R7
                  pll_feedback_divider <= nb[`BL_F_FB];
                  pll_clock_out        <= nb[`BL_F_MCLK];
                  pll_load             <= 1'b1;
                  mem_speed            <= nb[`BL_F_SPEED];
                  ptr                  <= nb[`BL_F_FIRST]; // R6
                  cnt                  <= 4'h0;
                  st                   <= bl_pkg::BHDR;
                end
                bl_pkg::BHDR: if (cnt == `BL_BHDR_END) begin // R8 R19
                  last     <= nb[`BL_F_LAST];
                  mem_bank <= nb[`BL_F_BANK]; // R11
                  base     <= nb[`BL_F_BASE]; // R12
                  left     <= nb[`BL_F_LEN]; // R13
                  cnt      <= 4'h0;
                  if (nb[`BL_F_LAST]) begin
                    jump <= nb[`BL_F_JUMP]; // R14
                  end
                  if (nb[`BL_F_LEN] != 16'h0000) begin
                    st <= bl_pkg::DATA;
                  end else if (nb[`BL_F_LAST]) begin
                    st <= bl_pkg::FOOT; // R9
                  end
                end
                bl_pkg::DATA: if (cnt[1:0] == `BL_WORD_END) begin
                  mem_wr_en <= 1'b1;
                  mem_addr  <= base;
                  mem_wdata <= nb[31:0];
                  base      <= base + 16'h0001; // R12
                  left      <= left - 16'h0001;
                  if (left == 16'h0001) begin // R13
                    cnt <= 4'h0;
                    st  <= last ? bl_pkg::FOOT : bl_pkg::BHDR; // R9
                  end
                end
                bl_pkg::FOOT: if (cnt == `BL_FOOT_END) begin // R17
                  st             <= bl_pkg::DONE;
                  core_run       <= 1'b1;
                  core_jump_addr <= jump; // R14
                end
                default: st <= bl_pkg::IDLE;
              endcase
            end
          end
        end
      endcase
    end
  end

  // register read mux; writes to read-only words are ignored
  always_comb begin
    rd = 32'h0000_0000;
    case (idx)
      `BL_IDX_FLAG:  rd = {29'h0, active, core_run, panic}; // R2
      `BL_IDX_CAUSE: rd = {26'h0, attempt, cause};
      `BL_IDX_CTRL:  rd = {31'h0, sw_go};
      default:       rd = 32'h0000_0000;
    endcase
  end

  // apb slave: read data latched in setup so the access phase never waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      if (setup) begin
        prdata <= rd;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_byte_in(bl_pkg::boot_state_t s, logic [3:0] c);
    got && !lk_nack && st == s && cnt == c;
  endsequence

  chk_panic_third: assert property ($rose(panic) |-> attempt == 2'h2 && core_sleep) // R1
    else $error("panic raised before the third attempt");
  chk_panic_quiet: assert property (active |-> !panic && !core_sleep) // R2
    else $error("panic shown while loading");
  chk_hdr_origin: assert property (st == bl_pkg::HDR && cnt == 4'h0 && !pend |-> ptr == 24'h0) // R4
    else $error("header read not from address zero");
  chk_bad_sentinel: assert property (s_byte_in(bl_pkg::HDR, 4'h0) ##0 rx != `BL_SENTINEL
    |=> cause == `BL_C_SENT) // R5
    else $error("bad sentinel not reported");
  chk_first_block: assert property (s_byte_in(bl_pkg::HDR, `BL_HDR_END) ##0 !fault
    |=> ptr == $past(nb[`BL_F_FIRST]) && st == bl_pkg::BHDR && pll_load) // R6
    else $error("first block pointer not taken");
  chk_bank_legal: assert property (mem_wr_en |-> mem_bank != `BL_BANK_BAD) // R11
    else $error("write to an illegal bank");
  chk_addr_step: assert property (mem_wr_en |-> base == 16'(mem_addr + 16'h0001)) // R12
    else $error("block address not stepping");
  chk_skip_zero: assert property (s_byte_in(bl_pkg::FOOT, `BL_FOOT_END) ##0 nb[63:0] == 64'h0
    |=> st == bl_pkg::DONE && core_run) // R17
    else $error("zero footer did not skip the check");
  chk_sum_panic: assert property (s_byte_in(bl_pkg::FOOT, `BL_FOOT_END) ##0
    (nb[63:0] != 64'h0 && nb[63:0] != sum) |=> cause == `BL_C_SUM && !core_run) // R16
    else $error("checksum mismatch not reported");
  chk_spi_frame: assert property (lk == bl_pkg::L_IDLE && lk_req && spi_mode
    |=> tx[39:32] == `BL_SPI_READ && !cs_lvl) // R23
    else $error("spi read frame wrong");
  chk_i2c_frame: assert property (lk == bl_pkg::L_IDLE && lk_req && !spi_mode
    |=> tx[39:32] == `BL_I2C_WR && tx[15:8] == `BL_I2C_RD) // R24
    else $error("i2c address frame wrong");
endmodule

// ### tb/spi_eeprom_model.sv
/*
  Behavioural serial eeprom on the spi side: mode 3, msb first, sequential read.
  Assumes the bench loads mem directly and resolves the select and clock wires.
*/
`timescale 1ns/1ps
module spi_eeprom_model (
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic mosi,
  output logic      miso,
  output logic      cmd_err
);
  // one part at one chip address; a part split across two addresses is a second model
  logic [7:0]  mem [0:255];
  logic [31:0] sh;
  logic [23:0] addr;
  int          nbit;
  initial begin
    miso = 1'b0;
    cmd_err = 1'b0;
    nbit = 0;
  end
  // new frame on select falling; a released line shows the inverse of its last bit
  always @(negedge cs_n) nbit = 0;
  always @(posedge cs_n) miso = ~miso;
  // command then 24-bit address shift in on rising clock, msb first
  always @(posedge sclk) if (!cs_n) begin
    sh = {sh[30:0], mosi};
    nbit = nbit + 1;
    if (nbit == 32) begin
      if (sh[31:24] !== 8'h03) cmd_err = 1'b1;
      addr = sh[23:0];
    end
  end
  // data leaves on the falling edge so it is settled at the next rise
  always @(negedge sclk) if (!cs_n && nbit >= 32) begin
    miso = mem[addr[7:0]][7 - (nbit - 32) % 8];
    if ((nbit - 32) % 8 == 7) addr = addr + 24'h1;
  end
endmodule

// ### tb/tb.sv
/*
  Self-checking bench for the boot loader: builds images in the eeprom model,
  boots over spi, starts an i2c load that no device answers, checks memory writes, pll values and status registers.
  Assumes the loader map header is on the include path.
*/
`timescale 1ns/1ps
`include "boot_loader_map.svh"
module tb;
  logic        pclk, presetn, psel, penable, pwrite, boot_enable_pin, use_spi, err;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, mem_speed, mem_wdata, rd, speed;
  logic        pready, pslverr, select_pin_o, select_pin_oe, mosi_o, mosi_oe, clk_pin_o;
  logic        clk_pin_oe, data_pin_o, data_pin_oe, pll_load, mem_wr_en, core_run;
  logic        core_sleep, miso, cmd_err;
  logic [7:0]  pll_input_divider, pll_feedback_divider, pll_clock_out, div, fb, mclk;
  logic [1:0]  mem_bank;
  logic [15:0] mem_addr, core_jump_addr, jump;
  logic [63:0] sum;
  logic [49:0] exp_q[$], got_q[$];
  int          ptr, n_mismatch, samples_checked, seed, n_pll;
  wire         cs_n         = select_pin_oe ? select_pin_o : 1'b1;
  wire         select_pin_i = cs_n & use_spi;               // strap low picks i2c
  wire         data_pin_i   = use_spi ? miso : ~data_pin_oe; // pulled-up sda, nobody acks

  eeprom_self_boot_loader #(.SPI_QTR(1), .I2C_QTR(2)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .boot_enable_pin, .select_pin_i, .select_pin_o, .select_pin_oe, .mosi_o,
    .mosi_oe, .clk_pin_o, .clk_pin_oe, .data_pin_i, .data_pin_o, .data_pin_oe,
    .pll_input_divider, .pll_feedback_divider, .pll_clock_out, .pll_load, .mem_speed,
    .mem_wr_en, .mem_bank, .mem_addr, .mem_wdata, .core_run, .core_jump_addr, .core_sleep);
  spi_eeprom_model u_mem (.cs_n, .sclk(clk_pin_oe ? clk_pin_o : 1'b1),
    .mosi(mosi_oe ? mosi_o : 1'b1), .miso, .cmd_err);

  always #10 pclk = ~pclk;
  // collect every memory write the loader issues
  always @(posedge pclk) if (mem_wr_en === 1'b1) got_q.push_back({mem_bank, mem_addr, mem_wdata});
  // count pll loads, one per accepted header
  always @(posedge pclk) if (pll_load === 1'b1) n_pll++;
  // the whole run needs about 57k cycles; a hang ends here as a failure
  initial begin
    #1_400_000;
    n_mismatch++;
    conclude;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; an idle edge follows so calls may run back to back
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // big-endian word into the eeprom, optionally counted in the running sum
  task automatic put(input logic [31:0] w, input logic add);
    for (int i = 0; i < 4; i++) u_mem.mem[ptr+i] = w[31-8*i -: 8];
    ptr += 4;
    if (add) sum += w;
  endtask
  // header with a four-byte gap before the first block, to prove the pointer is used
  task automatic image;
    ptr = 0;
    sum = 0;
    exp_q = {};
    got_q = {};
    n_pll = 0;
    div = 8'($urandom);
    fb = 8'($urandom);
    mclk = 8'($urandom);
    speed = $urandom;
    put({`BL_SENTINEL, 24'h000014}, 1'b1);
    put({8'h00, div, 8'h00, fb}, 1'b1);
    put({8'h00, div + fb + mclk, 8'h00, mclk}, 1'b1);
    put(speed, 1'b1);
    ptr = 'h14;
  endtask
  task automatic blk(input logic last, input logic [1:0] bank, input int n);
    logic [15:0] base;
    logic [31:0] w;
    base = 16'($urandom);
    jump = 16'($urandom); // earlier blocks' jumps must be ignored
    put({last, 13'h0, bank, base}, 1'b1);
    put({n[15:0], jump}, 1'b1);
    for (int i = 0; i < n; i++) begin
      w = $urandom;
      put(w, 1'b1);
      exp_q.push_back({bank, base + i[15:0], w});
    end
  endtask
  task automatic settle;
    while (core_run === 1'b1) @(posedge pclk);
    while (core_run !== 1'b1 && core_sleep !== 1'b1) @(posedge pclk);
  endtask
  task automatic boot;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    settle;
  endtask
  task automatic check_run;
    chk(core_run, 1'b1);
    chk(core_jump_addr, jump);
    chk(got_q.size(), exp_q.size());
    foreach (exp_q[i]) chk(got_q[i], exp_q[i]);
    chk({pll_input_divider, pll_feedback_divider, pll_clock_out}, {div, fb, mclk});
    chk(mem_speed, speed);
    chk(cmd_err, 1'b0);
    chk(n_pll, 1);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    boot_enable_pin = 1'b1;
    use_spi = 1'b1;
    n_mismatch = 0;
    samples_checked = 0;
    seed = $urandom(28);
    // three blocks, one per bank, lengths 1, 0 and 3
    image;
    for (int b = 0; b < 3; b++) blk(b == 2, b[1:0], b == 1 ? 0 : b + 1);
    put(sum[63:32], 1'b0);
    put(sum[31:0], 1'b0);
    boot;
    check_run;
    apb(1'b0, `BL_IDX_FLAG, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, `BL_IDX_FLAG, 32'hffffffff);
    apb(1'b0, `BL_IDX_FLAG, 32'h0);
    chk(rd, 32'h2);
    apb(1'b0, 16'h0000, 32'h0);
    chk({err, rd}, 33'h100000000);
    // zero footer with a wrong sum still boots; restarted by software
    image;
    blk(1'b1, 2'h2, 1);
    put(32'h0, 1'b0);
    put(32'h0, 1'b0);
    apb(1'b1, `BL_IDX_CTRL, 32'h1);
    settle;
    check_run;
    // a wrong nonzero footer fails all three attempts
    ptr -= 8;
    put(sum[63:32], 1'b0);
    put(sum[31:0] ^ 32'h1, 1'b0);
    boot;
    chk({core_sleep, core_run}, 2'b10);
    apb(1'b0, `BL_IDX_CAUSE, 32'h0);
    chk(rd, 32'h25);
    apb(1'b0, `BL_IDX_FLAG, 32'h0);
    chk(rd, 32'h1);
    // corrupt the block bank to 3, then the pll check byte, then the sentinel as well
    for (int k = 0; k < 3; k++) begin
      if (k == 0) u_mem.mem['h15] ^= 8'h01;
      else u_mem.mem[9 * (2 - k)] ^= 8'hff;
      boot;
      apb(1'b0, `BL_IDX_CAUSE, 32'h0);
      chk(rd, 32'h23 - k);
    end
    // strap low: i2c load with nobody answering at the device address
    use_spi <= 1'b0;
    boot;
    apb(1'b0, `BL_IDX_CAUSE, 32'h0);
    chk({core_sleep, rd}, {1'b1, 32'h24});
    // enable low at reset release: no load may start
    boot_enable_pin <= 1'b0;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (20) @(posedge pclk);
    apb(1'b0, `BL_IDX_FLAG, 32'h0);
    chk(rd, 32'h0);
    conclude;
  end
endmodule
